// ### logic/usart_ext.sv
/*
  Serial port core with infrared low-power coding, RS485 direction and
  address handling, synchronous master clock and 8-entry FIFOs.
  Assumes an AHB-Lite master with single word transfers and inputs that
  are synchronous to hclk.
*/
// Added by the designer: the AHB-Lite slave port.
// How it works
// - Low-power infrared transmit pulse lasts three prescaler values in clocks.
// - Infrared receive ignores low glitches shorter than two prescaler intervals.
// - Infrared low counts as zero only when longer than two intervals.
// - In RS485 mode the request-to-send pin enables the transceiver.
// - RS485 transmit drives the enable pin active while sending.
// - Normal multidrop drops address-bit-0 frames until an address frame.
// - Storing that first address sets the address-detected flag.
// - After the address, frames are stored only while receive is enabled.
// - Auto address stores matching address frames and enables receive.
// - A mismatching address disables receive; an address frame beats a same-cycle software write of the enable.
// - Synchronous mode is master only, clock always an output.
// - No clock pulses during start, parity and stop bits.
// - Phase picks first or second sampling edge; polarity the idle level.
// - Writing data starts a clocked transfer that also receives.
// - Receive time-out flag when no FIFO activity for programmed time.
// - Line status flags for overrun, parity, framing and break.
// - Transmit threshold flag while transmit FIFO is at low level.
// - Transmit complete only when FIFO empty and shifter idle.
// - Receive threshold flag once receive FIFO reaches its level.
// - Data read pops receive FIFO, masked to the word length.
// - Data write pushes transmit FIFO, masked to the word length.
// - Infrared sends zero as high pulse, receives low pulse as zero.
// - Two-bit mode field: normal, infrared, RS485, synchronous.
`timescale 1ns/10ps
module usart_ext #(
  parameter int DEPTH = 8,
  parameter int DW = 9
) (
  // Clock, reset, enable
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Serial pins
  input wire logic rxd,
  output logic txd,
  output logic rts_out,
  output logic sck_out,
  output logic irq
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  typedef logic [CW-1:0] cnt_t;

  // -----------------------------------------------------------------
  // State declarations
  // -----------------------------------------------------------------
  logic [DW-1:0] txm_q [DEPTH];
  logic [DW-1:0] txm_d [DEPTH];
  logic [DW-1:0] rxm_q [DEPTH];
  logic [DW-1:0] rxm_d [DEPTH];
  logic [AW-1:0] twp_q, twp_d, trp_q, trp_d, rwp_q, rwp_d, rrp_q, rrp_d;
  cnt_t tcn_q, tcn_d, rcn_q, rcn_d;
  logic [15:0] lc_q, lc_d, dl_q, dl_d;
  logic [3:0] fc_q, fc_d;
  logic [8:0] ie_q, ie_d;
  logic [6:0] tp_q, tp_d, to_q, to_d;
  logic [8:0] ir_q, ir_d;
  logic [10:0] md_q, md_d;
  logic [1:0] sy_q, sy_d;
  logic ts_q, ts_d;
  logic oei_q, oei_d, pei_q, pei_d, fei_q, fei_d, bii_q, bii_d;
  logic tof_q, tof_d, rsa_q, rsa_d, aseen_q, aseen_d;
  logic pend_q, pend_d, wr_q, wr_d, rdy_q, rdy_d, irq_q, irq_d;
  logic [7:0] adr_q, adr_d;
  logic [31:0] rd_q, rd_d;
  logic [15:0] bt_q, bt_d;
  usart_pkg::ser_state_t ts_st_q, ts_st_d, rs_st_q, rs_st_d;
  logic [15:0] tc_q, tc_d, rc_q, rc_d, ic_q, ic_d, zc_q, zc_d;
  logic [8:0] tsh_q, tsh_d, srx_q, srx_d, rsh_q, rsh_d;
  logic [3:0] tb_q, tb_d, rb_q, rb_d;
  logic tpar_q, tpar_d, tst_q, tst_d, rpar_q, rpar_d, prev_q, prev_d;
  logic txd_q, txd_d, rts_q, rts_d, sck_q, sck_d;
  logic [8:0] lowc_q, lowc_d;
  // Shared combinational terms
  usart_pkg::mode_t mode;
  logic [3:0] nbits;
  logic [8:0] wmask;
  logic nine, tx_pop, sy_push, rx_vld, line, bit_end, half;
  logic [8:0] sy_data;
  usart_pkg::rx_frame_t rfr;
  cnt_t rxlvl, txlvl;

  assign mode = usart_pkg::mode_t'(lc_q[1:0]);
  assign nine = (lc_q[9:8] == usart_pkg::WLS_9);
  assign nbits = usart_pkg::BITS_MIN + {2'h0, lc_q[9:8]};
  assign wmask = nine ? 9'h1FF : (lc_q[8] ? 9'h0FF : 9'h07F);
  assign bit_end = (tc_q == dl_q - 16'h0001);
  assign half = (tc_q == {1'b0, dl_q[15:1]});

  // FIFO threshold decode
  always_comb begin
    case (fc_q[3:2])
      2'h0: rxlvl = cnt_t'(1);
      2'h1: rxlvl = cnt_t'(2);
      2'h2: rxlvl = cnt_t'(4);
      default: rxlvl = cnt_t'(6);
    endcase
    case (fc_q[1:0])
      2'h0: txlvl = cnt_t'(0);
      2'h1: txlvl = cnt_t'(2);
      2'h2: txlvl = cnt_t'(4);
      default: txlvl = cnt_t'(6);
    endcase
  end

  // -----------------------------------------------------------------
  // Register bus, FIFOs and flags
  // -----------------------------------------------------------------
  // Next values of bus, registers, FIFO pointers and sticky flags
  always_comb begin
    logic store, rpop, tpush, aset;
    logic [8:0] clr;
    logic [31:0] stat;
    store = 1'b0;
    aset = 1'b0;
    rpop = 1'b0;
    tpush = 1'b0;
    clr = 9'h000;
    txm_d = txm_q;
    rxm_d = rxm_q;
    {twp_d, trp_d, rwp_d, rrp_d, tcn_d, rcn_d} = {twp_q, trp_q, rwp_q, rrp_q, tcn_q, rcn_q};
    {lc_d, dl_d, fc_d, ie_d, tp_d, ir_d, md_d, sy_d, ts_d} =
      {lc_q, dl_q, fc_q, ie_q, tp_q, ir_q, md_q, sy_q, ts_q};
    {oei_d, pei_d, fei_d, bii_d, tof_d, rsa_d, aseen_d} =
      {oei_q, pei_q, fei_q, bii_q, tof_q, rsa_q, aseen_q};
    rd_d = rd_q;
    adr_d = adr_q;
    wr_d = wr_q;
    pend_d = 1'b0;
    rdy_d = 1'b1;
    stat = {20'h0, 2'h0, rsa_q, (tcn_q == '0) && (ts_st_q == usart_pkg::ST_IDLE),
            tcn_q <= txlvl, tof_q, rcn_q >= rxlvl, bii_q, fei_q, pei_q, oei_q,
            rcn_q != '0};
    // Address phase: one wait state so read data comes from a flop
    if (hsel && htrans[1] && hready) begin
      pend_d = 1'b1;
      rdy_d = 1'b0;
      adr_d = haddr[7:0];
      wr_d = hwrite;
    end
    if (pend_q && wr_q) begin
      case (adr_q)
        usart_pkg::A_FIFO_DATA: tpush = (tcn_q != cnt_t'(DEPTH));
        usart_pkg::A_LINE_CTRL: lc_d = hwdata[15:0] & usart_pkg::LC_MASK;
        usart_pkg::A_FIFO_CTRL: begin
          fc_d = hwdata[7:4];
          if (hwdata[usart_pkg::FC_TXR]) begin
            {twp_d, trp_d, tcn_d} = '0;
          end
          if (hwdata[usart_pkg::FC_RXR]) begin
            {rwp_d, rrp_d, rcn_d} = '0;
          end
        end
        usart_pkg::A_IRQ_EN: ie_d = hwdata[8:0];
        usart_pkg::A_STATUS: clr = hwdata[9:1];
        usart_pkg::A_TIMING: tp_d = hwdata[6:0];
        usart_pkg::A_IR_CTRL: ir_d = {hwdata[15:8], hwdata[usart_pkg::IR_LP]};
        usart_pkg::A_MD_CTRL: md_d = {hwdata[15:8], hwdata[2:0]};
        usart_pkg::A_SYNC_CTRL: sy_d = hwdata[1:0];
        usart_pkg::A_BAUD_DIV: dl_d = hwdata[15:0];
        usart_pkg::A_TEST_CTRL: ts_d = hwdata[0];
        default: ;
      endcase
    end else if (pend_q) begin
      case (adr_q)
        usart_pkg::A_FIFO_DATA: begin
          rpop = (rcn_q != '0);
          rd_d = {23'h0, rxm_q[rrp_q]};
        end
        usart_pkg::A_LINE_CTRL: rd_d = {16'h0, lc_q};
        usart_pkg::A_FIFO_CTRL: rd_d = {4'h0, 4'(rcn_q), 4'h0, 4'(tcn_q), 8'h0, fc_q, 4'h0};
        usart_pkg::A_IRQ_EN: rd_d = {23'h0, ie_q};
        usart_pkg::A_STATUS: rd_d = stat;
        usart_pkg::A_TIMING: rd_d = {25'h0, tp_q};
        usart_pkg::A_IR_CTRL: rd_d = {16'h0, ir_q[8:1], 7'h0, ir_q[0]};
        usart_pkg::A_MD_CTRL: rd_d = {16'h0, md_q[10:3], 5'h0, md_q[2:0]};
        usart_pkg::A_SYNC_CTRL: rd_d = {30'h0, sy_q};
        usart_pkg::A_BAUD_DIV: rd_d = {16'h0, dl_q};
        usart_pkg::A_TEST_CTRL: rd_d = {31'h0, ts_q};
        default: rd_d = 32'h0;
      endcase
    end
    // Receive frame filter for the multidrop modes
    if (rx_vld && mode == usart_pkg::MODE_RS485 && md_q[usart_pkg::MD_NMM]) begin
      if (!aseen_q) begin
        store = rfr.addr_bit;
        aseen_d = rfr.addr_bit;
        aset = rfr.addr_bit;
      end else begin
        store = lc_q[usart_pkg::LC_RXEN];
      end
    end else if (rx_vld && mode == usart_pkg::MODE_RS485 && md_q[usart_pkg::MD_AAD]) begin
      if (rfr.addr_bit) begin
        store = (rfr.data[7:0] == md_q[10:3]);
        lc_d[usart_pkg::LC_RXEN] = store;
      end else begin
        store = lc_q[usart_pkg::LC_RXEN];
      end
    end else if (rx_vld || sy_push) begin
      store = lc_q[usart_pkg::LC_RXEN];
    end
    if (!md_q[usart_pkg::MD_NMM]) begin
      aseen_d = 1'b0;
    end
    // FIFO updates; a full receive FIFO drops the frame as overrun
    if (tpush) begin
      txm_d[twp_q] = hwdata[8:0] & wmask;
      twp_d = twp_q + 1'b1;
    end
    if (tx_pop) begin
      trp_d = trp_q + 1'b1;
    end
    tcn_d = tcn_d + cnt_t'(tpush) - cnt_t'(tx_pop);
    if (store && rcn_q != cnt_t'(DEPTH)) begin
      rxm_d[rwp_q] = sy_push ? sy_data : rfr.data;
      rwp_d = rwp_q + 1'b1;
    end
    if (rpop) begin
      rrp_d = rrp_q + 1'b1;
    end
    rcn_d = rcn_d + cnt_t'(store && rcn_q != cnt_t'(DEPTH)) - cnt_t'(rpop);
    // Sticky flags: a set in the clearing cycle wins
    oei_d = (oei_q & ~clr[0]) | (store && rcn_q == cnt_t'(DEPTH));
    pei_d = (pei_q & ~clr[1]) | (rx_vld & rfr.perr);
    fei_d = (fei_q & ~clr[2]) | (rx_vld & rfr.ferr);
    bii_d = (bii_q & ~clr[3]) | (rx_vld & rfr.brk);
    rsa_d = (rsa_q & ~clr[8]) | aset;
    // Time-out counts bit periods without FIFO activity
    bt_d = (bt_q >= dl_q - 16'h0001) ? 16'h0000 : bt_q + 16'h0001;
    to_d = to_q;
    if (store || rpop || rcn_q == '0) begin
      to_d = 7'h00;
    end else if (bt_q == 16'h0000 && to_q != tp_q) begin
      to_d = to_q + 7'h01;
    end
    tof_d = (tof_q & ~clr[5]) | (tp_q != 7'h00 && to_q == tp_q && rcn_q != '0);
    irq_d = |(ie_q & {stat[6], stat[9], stat[4:1], stat[8:7], stat[5]});
  end

  // Registers of the bus group
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {twp_q, trp_q, rwp_q, rrp_q, tcn_q, rcn_q} <= '0;
      {lc_q, fc_q, ie_q, tp_q, ir_q, md_q, sy_q, ts_q} <= '0;
      dl_q <= usart_pkg::DIV_RST;
      {oei_q, pei_q, fei_q, bii_q, tof_q, rsa_q, aseen_q} <= '0;
      {pend_q, wr_q, irq_q, adr_q, rd_q, bt_q, to_q} <= '0;
      rdy_q <= 1'b1;
      for (int i = 0; i < DEPTH; i++) begin
        txm_q[i] <= '0;
        rxm_q[i] <= '0;
      end
    end else if (clk_en) begin
      {twp_q, trp_q, rwp_q, rrp_q, tcn_q, rcn_q} <= {twp_d, trp_d, rwp_d, rrp_d, tcn_d, rcn_d};
      {lc_q, fc_q, ie_q, tp_q, ir_q, md_q, sy_q, ts_q} <=
        {lc_d, fc_d, ie_d, tp_d, ir_d, md_d, sy_d, ts_d};
      dl_q <= dl_d;
      {oei_q, pei_q, fei_q, bii_q, tof_q, rsa_q, aseen_q} <=
        {oei_d, pei_d, fei_d, bii_d, tof_d, rsa_d, aseen_d};
      {pend_q, wr_q, irq_q, adr_q, rd_q, bt_q, to_q} <=
        {pend_d, wr_d, irq_d, adr_d, rd_d, bt_d, to_d};
      rdy_q <= rdy_d;
      txm_q <= txm_d;
      rxm_q <= rxm_d;
    end
  end

  // -----------------------------------------------------------------
  // Transmitter, infrared modulator and synchronous clock
  // -----------------------------------------------------------------
  // Next values of the transmit engine and serial outputs
  always_comb begin
    logic ser;
    logic [15:0] plen;
    logic [8:0] w;
    ser = 1'b1;
    ts_st_d = ts_st_q;
    {tc_d, tb_d, tsh_d, tpar_d, tst_d, srx_d} = {tc_q, tb_q, tsh_q, tpar_q, tst_q, srx_q};
    tx_pop = 1'b0;
    sy_push = 1'b0;
    sy_data = 9'(srx_q >> (4'h9 - nbits));
    w = txm_q[trp_q] & wmask;
    plen = ir_q[0] ? {7'h00, ir_q[8:1], 1'b0} + {8'h00, ir_q[8:1]}
                   : 16'((dl_q * 3) >> 4);
    case (ts_st_q)
      usart_pkg::ST_START: ser = 1'b0;
      usart_pkg::ST_DATA: ser = tsh_q[0];
      usart_pkg::ST_PAR: ser = tpar_q;
      default: ser = 1'b1;
    endcase
    tc_d = (ts_st_q == usart_pkg::ST_IDLE || bit_end) ? 16'h0000 : tc_q + 16'h0001;
    case (ts_st_q)
      usart_pkg::ST_IDLE: begin
        if (tcn_q != '0 && lc_q[usart_pkg::LC_TXEN]) begin
          tx_pop = 1'b1;
          tsh_d = w;
          tpar_d = lc_q[usart_pkg::LC_EPE] ? ^w : ~^w;
          tb_d = 4'h0;
          tst_d = 1'b0;
          ts_st_d = usart_pkg::ST_START;
        end
      end
      usart_pkg::ST_START: begin
        if (bit_end) begin
          ts_st_d = usart_pkg::ST_DATA;
        end
      end
      usart_pkg::ST_DATA: begin
        if (half) begin
          srx_d = {rxd, srx_q[8:1]};
        end
        if (bit_end) begin
          tsh_d = {1'b0, tsh_q[8:1]};
          tb_d = tb_q + 4'h1;
          if (tb_q == nbits - 4'h1) begin
            ts_st_d = (lc_q[usart_pkg::LC_PBE] && !nine) ? usart_pkg::ST_PAR
                                                         : usart_pkg::ST_STOP;
          end
        end
      end
      usart_pkg::ST_PAR: begin
        if (bit_end) begin
          ts_st_d = usart_pkg::ST_STOP;
        end
      end
      usart_pkg::ST_STOP: begin
        if (bit_end) begin
          tst_d = 1'b1;
          if (tst_q || !lc_q[usart_pkg::LC_NSB]) begin
            ts_st_d = usart_pkg::ST_IDLE;
            sy_push = (mode == usart_pkg::MODE_SYNC);
          end
        end
      end
      default: ts_st_d = usart_pkg::ST_IDLE;
    endcase
    // Infrared pulse starts with each zero bit
    if (tc_q == 16'h0000 && ts_st_q != usart_pkg::ST_IDLE && !ser) begin
      ic_d = plen;
    end else begin
      ic_d = (ic_q != 16'h0000) ? ic_q - 16'h0001 : 16'h0000;
    end
    if (lc_q[usart_pkg::LC_BCB]) begin
      txd_d = 1'b0;
    end else if (mode == usart_pkg::MODE_IRDA) begin
      txd_d = (ic_q != 16'h0000);
    end else begin
      txd_d = ser;
    end
    if (mode == usart_pkg::MODE_RS485) begin
      rts_d = (ts_st_q != usart_pkg::ST_IDLE) ~^ md_q[usart_pkg::MD_POL];
    end else begin
      rts_d = ~lc_q[usart_pkg::LC_RTS];
    end
    // Clock only in data bits; always driven out
    sck_d = sy_q[usart_pkg::SY_CPO];
    if (mode == usart_pkg::MODE_SYNC && ts_st_q == usart_pkg::ST_DATA) begin
      sck_d = sy_q[usart_pkg::SY_CPO] ^ (sy_q[usart_pkg::SY_CPS] ? (tc_q < {1'b0, dl_q[15:1]})
                                                             : !(tc_q < {1'b0, dl_q[15:1]}));
    end
  end

  // Registers of the transmit group
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ts_st_q <= usart_pkg::ST_IDLE;
      {tc_q, tb_q, tsh_q, tpar_q, tst_q, srx_q, ic_q, sck_q} <= '0;
      txd_q <= 1'b1;
      rts_q <= 1'b1;
    end else if (clk_en) begin
      ts_st_q <= ts_st_d;
      {tc_q, tb_q, tsh_q, tpar_q, tst_q, srx_q, ic_q, sck_q} <=
        {tc_d, tb_d, tsh_d, tpar_d, tst_d, srx_d, ic_d, sck_d};
      txd_q <= txd_d;
      rts_q <= rts_d;
    end
  end

  // -----------------------------------------------------------------
  // Receiver and infrared demodulator
  // -----------------------------------------------------------------
  // Next values of the receive engine
  always_comb begin
    rs_st_d = rs_st_q;
    {rc_d, rb_d, rsh_d, rpar_d} = {rc_q, rb_q, rsh_q, rpar_q};
    rx_vld = 1'b0;
    rfr.data = 9'(rsh_q >> (4'h9 - nbits));
    rfr.addr_bit = rpar_q;
    rfr.perr = lc_q[usart_pkg::LC_PBE] && !nine && mode != usart_pkg::MODE_RS485 &&
               (rpar_q != (lc_q[usart_pkg::LC_EPE] ? ^rfr.data : ~^rfr.data));
    rfr.ferr = !line;
    rfr.brk = !line && rfr.data == 9'h000 && !rpar_q;
    // Low pulse longer than two prescaler intervals holds a zero for one bit
    lowc_d = rxd ? 9'h000 : (lowc_q == 9'h1FF ? lowc_q : lowc_q + 9'h001);
    if (!rxd && lowc_q == {ir_q[8:1], 1'b0}) begin
      zc_d = dl_q;
    end else begin
      zc_d = (zc_q != 16'h0000) ? zc_q - 16'h0001 : 16'h0000;
    end
    prev_d = line;
    rc_d = rc_q + 16'h0001;
    case (rs_st_q)
      usart_pkg::ST_IDLE: begin
        rc_d = 16'h0000;
        if (prev_q && !line && mode != usart_pkg::MODE_SYNC) begin
          rs_st_d = usart_pkg::ST_START;
        end
      end
      usart_pkg::ST_START: begin
        if (rc_q == {1'b0, dl_q[15:1]}) begin
          rc_d = 16'h0000;
          rb_d = 4'h0;
          rpar_d = 1'b0;
          rs_st_d = line ? usart_pkg::ST_IDLE : usart_pkg::ST_DATA;
        end
      end
      default: begin
        if (rc_q == dl_q - 16'h0001) begin
          rc_d = 16'h0000;
          if (rs_st_q == usart_pkg::ST_DATA) begin
            rsh_d = {line, rsh_q[8:1]};
            rb_d = rb_q + 4'h1;
            if (rb_q == nbits - 4'h1) begin
              rs_st_d = (lc_q[usart_pkg::LC_PBE] && !nine) ? usart_pkg::ST_PAR
                                                           : usart_pkg::ST_STOP;
            end
          end else if (rs_st_q == usart_pkg::ST_PAR) begin
            rpar_d = line;
            rs_st_d = usart_pkg::ST_STOP;
          end else begin
            rx_vld = 1'b1;
            rs_st_d = usart_pkg::ST_IDLE;
          end
        end
      end
    endcase
  end

  // Receive line source: loopback, infrared demodulator or pin
  assign line = ts_q ? txd_q : (mode == usart_pkg::MODE_IRDA ? (zc_q == 16'h0000) : rxd);

  // Registers of the receive group
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rs_st_q <= usart_pkg::ST_IDLE;
      {rc_q, rb_q, rsh_q, rpar_q, lowc_q, zc_q} <= '0;
      prev_q <= 1'b1;
    end else if (clk_en) begin
      rs_st_q <= rs_st_d;
      {rc_q, rb_q, rsh_q, rpar_q, lowc_q, zc_q} <= {rc_d, rb_d, rsh_d, rpar_d, lowc_d, zc_d};
      prev_q <= prev_d;
    end
  end

  // Outputs straight from flops, except hresp tied low
  assign hrdata = rd_q;
  assign hreadyout = rdy_q;
  assign hresp = 1'b0;
  assign txd = txd_q;
  assign rts_out = rts_q;
  assign sck_out = sck_q;
  assign irq = irq_q;
endmodule

// ### logic/usart_pkg.sv
/*
  Shared constants and types for the serial port with infrared, multidrop
  and synchronous master modes. Assumes a 32-bit register bus with one
  register per aligned word.
*/
package usart_pkg;
  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] A_FIFO_DATA = 8'h00;
  localparam logic [7:0] A_LINE_CTRL = 8'h04;
  localparam logic [7:0] A_FIFO_CTRL = 8'h08;
  localparam logic [7:0] A_IRQ_EN = 8'h0C;
  localparam logic [7:0] A_STATUS = 8'h10;
  localparam logic [7:0] A_TIMING = 8'h14;
  localparam logic [7:0] A_IR_CTRL = 8'h18;
  localparam logic [7:0] A_MD_CTRL = 8'h1C;
  localparam logic [7:0] A_SYNC_CTRL = 8'h20;
  localparam logic [7:0] A_BAUD_DIV = 8'h24;
  localparam logic [7:0] A_TEST_CTRL = 8'h28;
  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int LC_TXEN = 4;
  localparam int LC_RXEN = 5;
  localparam int LC_NSB = 10;
  localparam int LC_PBE = 11;
  localparam int LC_EPE = 12;
  localparam int LC_BCB = 14;
  localparam int LC_RTS = 15;
  localparam logic [15:0] LC_MASK = 16'hFF3F;
  localparam int FC_TXR = 0;
  localparam int FC_RXR = 1;
  localparam int IR_LP = 0;
  localparam int MD_POL = 0;
  localparam int MD_NMM = 1;
  localparam int MD_AAD = 2;
  localparam int SY_CPS = 0;
  localparam int SY_CPO = 1;
  localparam logic [15:0] DIV_RST = 16'h0010;
  localparam logic [1:0] WLS_9 = 2'h2;
  localparam logic [3:0] BITS_MIN = 4'h7;
  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,
    MODE_IRDA = 2'b01,
    MODE_RS485 = 2'b10,
    MODE_SYNC = 2'b11
  } mode_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_START = 3'b001,
    ST_DATA = 3'b010,
    ST_PAR = 3'b011,
    ST_STOP = 3'b100
  } ser_state_t;
  typedef struct packed {
    logic [8:0] data;
    logic addr_bit;
    logic perr;
    logic ferr;
    logic brk;
  } rx_frame_t;
endpackage

// ### verification/usart_ext_assertions.sv
/*
  Checker for bus timing and pin behaviour of the serial port.
  Assumes hready is fed back from hreadyout and sees only top ports.
*/
`timescale 1ns/10ps
module usart_ext_assertions (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // Pins
  input wire logic txd,
  input wire logic rts_out,
  input wire logic sck_out,
  input wire logic irq
);
  logic w_q;
  logic [7:0] a_q;
  logic [1:0] mode_q;
  logic [15:0] ir_q;
  logic pol_q;
  logic [15:0] hi_q;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ---------------------------------------------------------------
  // Shadow of mode registers and length of the current high level
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      w_q <= 1'b0;
      a_q <= 8'h00;
      mode_q <= 2'h0;
      ir_q <= 16'h0000;
      pol_q <= 1'b0;
      hi_q <= 16'h0000;
    end else begin
      if (hready) begin
        w_q <= hsel && htrans[1] && hwrite;
        a_q <= haddr[7:0];
      end
      if (w_q && hready && a_q == usart_pkg::A_LINE_CTRL) begin
        mode_q <= hwdata[1:0];
      end
      if (w_q && hready && a_q == usart_pkg::A_IR_CTRL) begin
        ir_q <= hwdata[15:0];
      end
      if (w_q && hready && a_q == usart_pkg::A_MD_CTRL) begin
        pol_q <= hwdata[0];
      end
      hi_q <= txd ? hi_q + 16'h0001 : 16'h0000;
    end
  end
  chk_wait_state: assert property (hsel && htrans[1] && hready |=> !hreadyout ##1 hreadyout)
    else $error("wait state sequence wrong");
  chk_idle_ready: assert property (!hreadyout |-> $past(hsel && htrans[1] && hready))
    else $error("wait state without request");
  chk_resp_okay: assert property (hresp == 1'b0)
    else $error("response not okay");
  chk_rdata_hold: assert property ($changed(hrdata) |-> !$past(hreadyout))
    else $error("read data moved outside a transfer");
  chk_reset_idle: assert property ($rose(hresetn) |-> txd && hreadyout && !irq)
    else $error("idle levels wrong after reset");
  chk_start_bit: assert property (mode_q == 2'b00 && $fell(txd) |-> !txd [*8])
    else $error("start bit too short");
  chk_ir_pulse: assert property (mode_q == 2'b01 && $past(mode_q) == 2'b01 && ir_q[0]
    && $fell(txd) && hi_q < 16'h0400 |-> hi_q == 16'(3 * ir_q[15:8]))
    else $error("infrared pulse width wrong");
  chk_rts_drive: assert property (mode_q == 2'b10 && $fell(txd) |-> rts_out == pol_q)
    else $error("transceiver enable not active");
  // Synchronous clock idles low through start and stop, pulses mid data bit
  chk_sck_start: assert property (mode_q == 2'b11 && $fell(txd)
    |-> !sck_out [*8] ##17 sck_out)
    else $error("clock wrong around start bit");
  chk_sck_stop: assert property (mode_q == 2'b11 && $rose(txd) |-> !sck_out [*8])
    else $error("clock pulse in stop bit");
  cover property (w_q && hready);
  cover property (mode_q == 2'b01 && $fell(txd));
  cover property (mode_q == 2'b10 && $fell(txd));
endmodule
bind usart_ext usart_ext_assertions u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
  .hwdata, .hready, .hrdata, .hreadyout, .hresp, .txd, .rts_out, .sck_out, .irq);

// ### verification/usart_ext_tb_top.sv
/*
  Self-checking bench for the serial port over AHB-Lite.
  Assumes the checker is bound and the partner drives rxd.
*/
`timescale 1ns/10ps
module usart_ext_tb_top;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, rxd, txd, rts_out, irq;
  logic cmp = 1'b0;
  logic [63:0] notes[$];
  logic [31:0] r;
  logic [7:0] b;
  int num_errors = 0;
  int check_count = 0;
  always #5 hclk = ~hclk;
  usart_ext u_dut (.hclk(hclk), .hresetn(hresetn), .clk_en(1'b1), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rxd(rxd), .txd(txd),
    .rts_out(rts_out), .sck_out(), .irq(irq));
  usart_partner u_peer (.hclk(hclk), .rxd(rxd));
  // ---------------------------------------------------------------
  // Bus tasks and result monitor
  // ---------------------------------------------------------------
  task automatic wrap_up();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic wait_rdy();
    int n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 64);
    if (hreadyout !== 1'b1) begin
      num_errors++;
      wrap_up();
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic c);
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    cmp <= 1'b0;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    cmp <= c;
    wait_rdy();
    r = hrdata;
  endtask
  task automatic chk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    notes.push_back({m, e});
    xfer(1'b0, a, 32'h0, 1'b1);
  endtask
  task automatic poll(input int k);
    int n = 0;
    do begin
      xfer(1'b0, usart_pkg::A_STATUS, 32'h0, 1'b0);
      n++;
    end while (r[k] !== 1'b1 && n < 200);
    if (r[k] !== 1'b1) begin
      num_errors++;
      wrap_up();
    end
  endtask
  // Oldest note against each completed checked read
  always @(posedge hclk) begin
    if (cmp && hreadyout === 1'b1 && notes.size() > 0) begin
      check_count++;
      if ((hrdata & notes[0][63:32]) !== notes[0][31:0]) begin
        num_errors++;
        $display("unexpected hrdata: expected %h seen %h", notes[0][31:0], hrdata);
      end
      void'(notes.pop_front());
    end
  end
  // Reset values, loopback, infrared, multidrop
  initial begin
    void'($urandom(60385));
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 12; i++) begin
      chk(8'(i * 4), i == 4 ? 32'h180 : (i == 9 ? 32'h10 : 32'h0), 32'hFFFFFFFF);
    end
    xfer(1'b1, usart_pkg::A_TEST_CTRL, 32'h1, 1'b0);
    for (int k = 0; k < 2; k++) begin
      b = 8'($urandom);
      xfer(1'b1, usart_pkg::A_LINE_CTRL, k ? 32'h230 : 32'h130, 1'b0);
      xfer(1'b1, usart_pkg::A_FIFO_DATA, {23'h0, 1'b1, b}, 1'b0);
      chk(usart_pkg::A_STATUS, 32'h0, 32'h100);
      poll(0);
      chk(usart_pkg::A_FIFO_DATA, {23'h0, k[0], b}, 32'h1FF);
      poll(8);
    end
    xfer(1'b1, usart_pkg::A_TEST_CTRL, 32'h0, 1'b0);
    xfer(1'b1, usart_pkg::A_IR_CTRL, 32'h0401, 1'b0);
    xfer(1'b1, usart_pkg::A_LINE_CTRL, 32'h111, 1'b0);
    xfer(1'b1, usart_pkg::A_FIFO_DATA, 32'h55, 1'b0);
    poll(8);
    xfer(1'b1, usart_pkg::A_MD_CTRL, 32'h3, 1'b0);
    xfer(1'b1, usart_pkg::A_LINE_CTRL, 32'h912, 1'b0);
    xfer(1'b1, usart_pkg::A_FIFO_DATA, 32'hA5, 1'b0);
    u_peer.send(8'h33, 1'b0);
    u_peer.send(8'h5A, 1'b1);
    u_peer.send(8'h77, 1'b0);
    poll(9);
    chk(usart_pkg::A_FIFO_DATA, 32'h5A, 32'h1FF);
    chk(usart_pkg::A_STATUS, 32'h0, 32'h1);
    xfer(1'b1, usart_pkg::A_LINE_CTRL, 32'h133, 1'b0);
    xfer(1'b1, usart_pkg::A_FIFO_DATA, 32'h0, 1'b0);
    poll(0);
    chk(usart_pkg::A_FIFO_DATA, 32'hFF, 32'h1FF);
    wrap_up();
  end
endmodule

// ### verification/usart_partner.sv
/*
  Far-side transceiver model that sends frames on the receive line.
  Assumes the bench calls send right after a rising clock edge.
*/
`timescale 1ns/10ps
module usart_partner #(
  parameter int BIT_CYCLES = 16
) (
  // Line
  input wire logic hclk,
  output logic rxd
);
  // Biased line rests high
  initial rxd = 1'b1;
  // Start, eight data bits low first, address bit, stop
  task automatic send(input logic [7:0] d, input logic p);
    logic [10:0] f;
    f = {1'b1, p, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      rxd <= f[i];
      repeat (BIT_CYCLES) @(posedge hclk);
    end
  endtask
endmodule
